// [rtl/dhar_addr_latch.sv]
// dma address byte latch and a[16:8] pin drive
`timescale 1ns/1ps
`include "dhar_defs.svh"
module dhar_addr_latch
  import dhar_pkg::*;
#(
  parameter int W = `DHAR_MID_W
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_i,
  input  wire logic                   load_byte_i,
  input  wire logic                   load_word_i,
  input  wire logic                   byte_cycle_i,
  input  wire logic                   word_cycle_i,
  input  wire logic [W-1:0]           data_i,
  output dhar_pkg::dhar_addr_pins_t   pins_o
);
  logic [W-1:0]              addr;
  logic [W-1:0]              next_addr;
  dhar_addr_pins_t           next_pins;

  // ==========================================================
  // latch
  always_comb begin
    next_addr = addr;
    if (load_byte_i || load_word_i) begin
      next_addr = data_i;
    end
  end

  // ==========================================================
  // pin placement: byte cycle sits at 15:8, word cycle at 16:9
  always_comb begin
    next_pins = '0;
    if (word_cycle_i) begin
      next_pins.out = {1'b0, next_addr} << `DHAR_WORD_LSB;
      next_pins.oe  = {{W{1'b1}}, 1'b0};
    end else if (byte_cycle_i) begin
      next_pins.out = {1'b0, next_addr} << `DHAR_BYTE_LSB;
      next_pins.oe  = {1'b0, {W{1'b1}}};
    end
  end

  // latch and pin registers
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      addr   <= '0;
      pins_o <= '0;
    end else begin
      addr   <= next_addr;
      pins_o <= next_pins;
    end
  end
endmodule

// [rtl/dhar_defs.svh]
// constants for the dma hold arbiter
`ifndef DHAR_DEFS_SVH
`define DHAR_DEFS_SVH
`define DHAR_ADDR_W       9
`define DHAR_BYTE_LSB     0
`define DHAR_WORD_LSB     1
`define DHAR_ADDR_RST     9'h000
`define DHAR_MID_W        8
`define DHAR_CTL_RST      4'h3
`define DHAR_DATA_RST     8'h00
`endif

// [rtl/dhar_pkg.sv]
// types shared by the dma hold arbiter files
`include "dhar_defs.svh"
package dhar_pkg;
  // arbitration states
  typedef enum logic [1:0] {
    DHAR_IDLE,
    DHAR_WAIT_CPU,
    DHAR_GRANTED,
    DHAR_RELEASE
  } dhar_state_t;
  // dma strobe and enable group
  typedef struct packed {
    logic byte_strobe;
    logic word_strobe;
    logic byte_enable_n;
    logic word_enable_n;
  } dhar_dma_ctl_t;
  // address pin group for a[16:8]
  typedef struct packed {
    logic [`DHAR_ADDR_W-1:0] out;
    logic [`DHAR_ADDR_W-1:0] oe;
  } dhar_addr_pins_t;
endpackage

// [rtl/dhar_top.sv]
// hold arbitration and dma address relay
`timescale 1ns/1ps
`include "dhar_defs.svh"
module dhar_top
  import dhar_pkg::*;
(
  input  wire logic                          clk_sys_i,
  input  wire logic                          reset_i,
  input  wire logic                          ipc_hold_request_i,
  input  wire logic                          cpu_grant_i,
  input  dhar_pkg::dhar_dma_ctl_t            dma_ctl_i,
  input  wire logic [`DHAR_MID_W-1:0]        peripheral_data_low_i,
  output logic                               cpu_hold_o,
  output logic                               ipc_hold_grant_o,
  output logic [`DHAR_ADDR_W-1:0]            cpu_addr_o,
  output logic [`DHAR_ADDR_W-1:0]            cpu_addr_oe_o
);
  import dhar_pkg::*;

  // ==========================================================
  // pin synchronisers: stage one is read only by stage two
  // every input here comes off the board on its own timing, so
  // nothing past this section ever looks at a raw pin
  logic                      req_s1;
  logic                      req_s2;
  logic                      grant_s1;
  logic                      grant_s2;
  dhar_dma_ctl_t             ctl_s1;
  dhar_dma_ctl_t             ctl_s2;
  logic [`DHAR_MID_W-1:0]    data_s1;
  logic [`DHAR_MID_W-1:0]    data_s2;
  dhar_dma_ctl_t             ctl_prev;
  logic                      next_req_s1;
  logic                      next_req_s2;
  logic                      next_grant_s1;
  logic                      next_grant_s2;
  dhar_dma_ctl_t             next_ctl_s1;
  dhar_dma_ctl_t             next_ctl_s2;
  dhar_dma_ctl_t             next_ctl_prev;
  logic [`DHAR_MID_W-1:0]    next_data_s1;
  logic [`DHAR_MID_W-1:0]    next_data_s2;

  // hold link: each pin walks its own two stages
  always_comb begin
    next_req_s1   = ipc_hold_request_i;
    next_req_s2   = req_s1;
    next_grant_s1 = cpu_grant_i;
    next_grant_s2 = grant_s1;
  end

  // hold link registers, reset to the idle low level
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      req_s1   <= 1'b0;
      req_s2   <= 1'b0;
      grant_s1 <= 1'b0;
      grant_s2 <= 1'b0;
    end else begin
      req_s1   <= next_req_s1;
      req_s2   <= next_req_s2;
      grant_s1 <= next_grant_s1;
      grant_s2 <= next_grant_s2;
    end
  end

  // dma pins: strobes, enables and data share one depth, so the
  // byte taken on a strobe edge is the byte that stood beside it
  always_comb begin
    next_ctl_s1   = dma_ctl_i;
    next_ctl_s2   = ctl_s1;
    next_ctl_prev = ctl_s2;
    next_data_s1  = peripheral_data_low_i;
    next_data_s2  = data_s1;
  end

  // reset to the idle pin pattern (strobes low, enables high) so
  // the edge detector sees no false strobe right after reset
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ctl_s1   <= `DHAR_CTL_RST;
      ctl_s2   <= `DHAR_CTL_RST;
      ctl_prev <= `DHAR_CTL_RST;
      data_s1  <= `DHAR_DATA_RST;
      data_s2  <= `DHAR_DATA_RST;
    end else begin
      ctl_s1   <= next_ctl_s1;
      ctl_s2   <= next_ctl_s2;
      ctl_prev <= next_ctl_prev;
      data_s1  <= next_data_s1;
      data_s2  <= next_data_s2;
    end
  end

  // ==========================================================
  // helpers shared by both strobes and both enables

  // a strobe counts once, on the clock its synced level rises, so
  // a strobe held high for many clocks loads only one byte
  function automatic logic rise_of(input logic now_lvl,
                                   input logic last_lvl);
    return now_lvl && !last_lvl;
  endfunction

  // an enable opens a cycle only while the bus is granted, so a
  // stray enable can never drive lines the cpu still owns
  function automatic logic cycle_of(input logic enable_n,
                                    input logic granted);
    return !enable_n && granted;
  endfunction

  // ==========================================================
  // strobe edges and cycle decode
  logic byte_load;
  logic word_load;
  logic byte_cycle;
  logic word_cycle;

  // strobes act on their rising edge, data sampled alongside
  assign byte_load  = rise_of(ctl_s2.byte_strobe,
                              ctl_prev.byte_strobe);
  assign word_load  = rise_of(ctl_s2.word_strobe,
                              ctl_prev.word_strobe);
  // dma only counts while the bus is actually granted
  assign byte_cycle = cycle_of(ctl_s2.byte_enable_n,
                               ipc_hold_grant_o);
  assign word_cycle = cycle_of(ctl_s2.word_enable_n,
                               ipc_hold_grant_o);

  // ==========================================================
  // arbitration state machine
  // idle     : nothing asked, both outputs low
  // wait_cpu : hold raised, cpu still floating its pins
  // granted  : cpu let go, grant passed on to the controller
  // release  : grant withdrawn; a new request waits until the
  //            cpu has taken its own grant back
  dhar_state_t state;
  dhar_state_t next_state;
  logic        next_hold;
  logic        next_grant;

  // next state and next outputs
  always_comb begin
    next_state = state;
    next_hold  = cpu_hold_o;
    next_grant = ipc_hold_grant_o;
    unique case (state)
      DHAR_IDLE: begin
        if (req_s2) begin
          next_state = DHAR_WAIT_CPU;
          next_hold  = 1'b1;
        end
      end
      DHAR_WAIT_CPU: begin
        // cpu grants only after floating its pins
        if (!req_s2) begin
          next_state = DHAR_RELEASE;
          next_hold  = 1'b0;
        end else if (grant_s2) begin
          next_state = DHAR_GRANTED;
          next_grant = 1'b1;
        end
      end
      DHAR_GRANTED: begin
        if (!req_s2 || !grant_s2) begin
          next_state = DHAR_RELEASE;
          next_grant = 1'b0;
          next_hold  = req_s2;
        end
      end
      DHAR_RELEASE: begin
        // wait for the cpu to take its grant back first
        next_grant = 1'b0;
        next_hold  = 1'b0;
        if (!grant_s2) begin
          next_state = DHAR_IDLE;
        end
      end
    endcase
  end

  // state and output registers
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state            <= DHAR_IDLE;
      cpu_hold_o       <= 1'b0;
      ipc_hold_grant_o <= 1'b0;
    end else begin
      state            <= next_state;
      cpu_hold_o       <= next_hold;
      ipc_hold_grant_o <= next_grant;
    end
  end

  // ==========================================================
  // address relay
  // the byte is latched on every strobe edge, granted or not;
  // only the drive onto the pins waits for the grant
  dhar_addr_pins_t pins;

  dhar_addr_latch #(
    .W (`DHAR_MID_W)
  ) u_latch (
    .clk_sys_i    (clk_sys_i),
    .reset_i      (reset_i),
    .load_byte_i  (byte_load),
    .load_word_i  (word_load),
    .byte_cycle_i (byte_cycle),
    .word_cycle_i (word_cycle),
    .data_i       (data_s2),
    .pins_o       (pins)
  );

  // pins come straight from the latch flip-flops
  assign cpu_addr_o    = pins.out;
  assign cpu_addr_oe_o = pins.oe;
endmodule

// [tb/dhar_cpu_model.sv]
// behavioural host cpu answering the hold output
`timescale 1ns/1ps
// ==========
module dhar_cpu_model (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic       hold_i,
  input  wire logic [3:0] delay_i,
  output logic            grant_o
);
  logic [3:0] cnt;
  // delay stands for the time the cpu needs to float its pins
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !hold_i) begin
      cnt     <= 4'h0;
      grant_o <= 1'b0;
    end else if (cnt < delay_i) cnt <= cnt + 4'h1; // float first
    else grant_o <= 1'b1; // then acknowledge
  end
endmodule

// [tb/dhar_top_chk.sv]
// port assertions for the hold arbiter
`timescale 1ns/1ps
`include "dhar_defs.svh"
// ==========
module dhar_top_chk
  import dhar_pkg::*;
(
  input wire logic                   clk_sys_i,
  input wire logic                   reset_i,
  input wire logic                   ipc_hold_request_i,
  input wire logic                   cpu_grant_i,
  input dhar_pkg::dhar_dma_ctl_t     dma_ctl_i,
  input wire logic [`DHAR_MID_W-1:0] peripheral_data_low_i,
  input wire logic                   cpu_hold_o,
  input wire logic                   ipc_hold_grant_o,
  input wire logic [`DHAR_ADDR_W-1:0] cpu_addr_o,
  input wire logic [`DHAR_ADDR_W-1:0] cpu_addr_oe_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // only the two documented lane patterns may drive
  property p_oe_set; cpu_addr_oe_o inside {9'h000, 9'h0FF, 9'h1FE}; endproperty
  a_oe_set: assert property (p_oe_set) else $error("bad oe");
  property p_oe_grant;
    cpu_addr_oe_o != 9'h000 |-> ipc_hold_grant_o || $past(ipc_hold_grant_o);
  endproperty
  a_oe_grant: assert property (p_oe_grant) else $error("oe no dma");
  property p_grant_hold; ipc_hold_grant_o |-> cpu_hold_o; endproperty
  a_grant_hold: assert property (p_grant_hold) else $error("grant");
  property p_hold_req; $rose(cpu_hold_o) |-> $past(ipc_hold_request_i, 2);
  endproperty
  a_hold_req: assert property (p_hold_req) else $error("hold src");
  property p_grant_cpu; $rose(ipc_hold_grant_o) |-> $past(cpu_grant_i, 2);
  endproperty
  a_grant_cpu: assert property (p_grant_cpu) else $error("ack");
  property p_req_hold;
    $rose(ipc_hold_request_i) && !cpu_grant_i |-> ##[2:8] cpu_hold_o;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("no hold");
  property p_drop;
    $fell(ipc_hold_request_i) |-> ##3 !cpu_hold_o && !ipc_hold_grant_o;
  endproperty
  a_drop: assert property (p_drop) else $error("no drop");
  property p_addr_src;
    $changed(cpu_addr_o) && $stable(cpu_addr_oe_o) |->
      $past(dma_ctl_i.byte_strobe, 2) || $past(dma_ctl_i.word_strobe, 2);
  endproperty
  a_addr_src: assert property (p_addr_src) else $error("addr");
endmodule
bind dhar_top dhar_top_chk i_dhar_top_chk (.clk_sys_i, .reset_i,
  .ipc_hold_request_i, .cpu_grant_i, .dma_ctl_i, .peripheral_data_low_i,
  .cpu_hold_o, .ipc_hold_grant_o, .cpu_addr_o, .cpu_addr_oe_o);

// [tb/tb_dma_hold_arbiter.sv]
// self-checking bench for the hold arbiter
`timescale 1ns/1ps
// ==========
module tb_dma_hold_arbiter;
  import dhar_pkg::*;
  logic          clk = 0, rst = 1, req = 0, cgnt, hold, gnt;
  dhar_dma_ctl_t ctl = 4'h3;
  logic [7:0]    data = 8'h00;
  logic [8:0]    addr, oe;
  logic [3:0]    dly = 4'h0;
  logic [31:0]   seed = 32'h0000_0016;
  int            errors = 0, num_checks = 0, n;
  always #2 clk = ~clk;
  dhar_top i_dhar_top (.clk_sys_i(clk), .reset_i(rst),
    .ipc_hold_request_i(req), .cpu_grant_i(cgnt), .dma_ctl_i(ctl),
    .peripheral_data_low_i(data), .cpu_hold_o(hold),
    .ipc_hold_grant_o(gnt), .cpu_addr_o(addr), .cpu_addr_oe_o(oe));
  dhar_cpu_model i_dhar_cpu_model (.clk_sys_i(clk), .reset_i(rst),
    .hold_i(hold), .delay_i(dly), .grant_o(cgnt));
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // word lane wins when both enables are low
  function logic [8:0] exp_oe(logic [1:0] m, logic g);
    return !g ? 9'h000 : m[1] ? 9'h1FE : 9'h0FF;
  endfunction
  task cmp(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // m[1] word cycle, m[0] byte cycle; data held well around the strobe
  task dma(input logic [1:0] m, input logic g);
    logic [8:0] e;
    e = exp_oe(m, g);
    @(negedge clk) ctl = {2'b00, ~m[0], ~m[1]};
    data = 8'(xs());
    repeat (3) @(negedge clk);
    ctl[3:2] = {m[0], m[1]};
    repeat (4) @(negedge clk);
    ctl[3:2] = 2'b00;
    repeat (2) @(negedge clk);
    cmp(oe, e);
    cmp(addr & e, (m[1] ? {data, 1'b0} : {1'b0, data}) & e);
    ctl = 4'h3;
    repeat (6) @(negedge clk);
    cmp(oe, 9'h000);
  endtask
  task final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog well beyond the few hundred cycles of the run
  initial begin
    #200000;
    errors++;
    final_report();
  end
  initial begin
    repeat (5) @(negedge clk);
    cmp({hold, gnt, oe[6:0]}, 9'h000);
    rst = 0;
    for (int i = 0; i < 6; i++) begin
      dly = 4'(i * 3);
      dma(2'b11, 1'b0); // no drive without the hold handshake
      @(negedge clk) req = 1;
      for (n = 0; hold !== 1'b1 && n < 20; n++) @(negedge clk);
      cmp(9'(n), 9'h003);
      for (n = 0; gnt !== 1'b1 && n < 40; n++) @(negedge clk);
      cmp({cgnt, gnt, hold}, 9'h007);
      for (int m = 1; m < 4; m++) dma(2'(m), 1'b1);
      req = 0;
      repeat (4) @(negedge clk);
      cmp({hold, gnt}, 9'h000);
      repeat (8) @(negedge clk);
    end
    final_report();
  end
endmodule
